// File: design/drive_status_lamps.sv
// Drive status lamp decoder with Avalon-MM register access
`timescale 1ns/1ps

module drive_status_lamps #(
  parameter int unsigned BLINK_HALF_CYC = lamp_pkg::BLINK_HALF_CYC,
  parameter int          FREQ_W         = 16
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              RSTN_I,
  // Avalon-MM slave
  input  wire logic [3:0]        AVS_ADDRESS_I,
  input  wire logic              AVS_READ_I,
  input  wire logic              AVS_WRITE_I,
  input  wire logic [3:0]        AVS_BYTEENABLE_I,
  input  wire logic [31:0]       AVS_WRITEDATA_I,
  output logic      [31:0]       AVS_READDATA_O,
  output logic                   AVS_WAITREQUEST_O,
  // Drive sequencing status
  input  wire logic              RUN_FWD_I,
  input  wire logic              RUN_REV_I,
  input  wire logic              FAULT_I,
  input  wire logic              ALARM_I,
  input  wire logic              RUNNING_I,
  input  wire logic              DECELERATING_I,
  input  wire logic [FREQ_W-1:0] FREQ_REF_I,
  input  wire logic              STOP_KEY_I,
  input  wire logic              LOCAL_REMOTE_KEY_I,
  // Lamps and mode
  output logic                   FORWARD_RUN_LAMP_O,
  output logic                   REVERSE_RUN_LAMP_O,
  output logic                   ALARM_LAMP_O,
  output logic                   REMOTE_RUN_SOURCE_LAMP_O,
  output logic                   REMOTE_REF_SOURCE_LAMP_O,
  output logic                   RUN_LAMP_O,
  output logic                   STOP_LAMP_O,
  output logic                   REMOTE_MODE_O
);

  // Bus slave state
  lamp_pkg::bus_state_t bus_state_q;
  logic                 waitreq_q;
  logic [31:0]          rdata_q;
  logic                 req;
  logic                 commit_wr;

  // Software settings
  logic [1:0]          run_command_source_sel_q;
  logic [2:0]          frequency_reference_source_sel_q;
  logic                local_remote_key_enable_q;
  logic [FREQ_W-1:0]   minimum_output_frequency_q;

  // Block state
  logic                remote_q;
  logic                stop_key_seen_q;
  logic                blink_phase;

  // Lamp flops
  logic                fwd_lamp_q;
  logic                rev_lamp_q;
  logic                alarm_lamp_q;
  logic                seq_lamp_q;
  logic                ref_lamp_q;
  logic                run_lamp_q;
  logic                stop_lamp_q;

  // Lamp modes before blink resolution
  lamp_pkg::lamp_mode_t alarm_mode;
  lamp_pkg::lamp_mode_t run_mode;
  lamp_pkg::lamp_mode_t stop_mode;

  // Register views and write merge
  localparam int       RL = lamp_pkg::CTRL_RUN_SEL_LSB;
  localparam int       FL = lamp_pkg::CTRL_REF_SEL_LSB;
  logic [31:0]         ctrl_word;
  logic [31:0]         minf_word;
  logic [31:0]         stat_word;
  logic [31:0]         input_word;
  logic [31:0]         wmask;
  logic [31:0]         ctrl_new;
  logic [31:0]         minf_new;
  logic [31:0]         rd_mux;

  // Derived conditions
  logic                run_cmd;
  logic                ref_below_min;
  logic                seq_remote_src;
  logic                ref_remote_src;

  lamp_blink_gen #(
    .HALF_CYC (BLINK_HALF_CYC)
  ) u_blink (
    .clk_i   (SYS_CLK_I),
    .rstn_i  (RSTN_I),
    .phase_o (blink_phase)
  );

  assign req       = AVS_READ_I | AVS_WRITE_I;
  // Write lands on the edge where waitrequest is seen low
  assign commit_wr = (bus_state_q == lamp_pkg::BUS_ACK) & AVS_WRITE_I;

  // One wait cycle, then a single acknowledge cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      bus_state_q <= lamp_pkg::BUS_IDLE;
    end else begin
      unique case (bus_state_q)
        lamp_pkg::BUS_IDLE: begin
          if (req) begin
            bus_state_q <= lamp_pkg::BUS_ACK;
          end
        end
        lamp_pkg::BUS_ACK: begin
          bus_state_q <= lamp_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Waitrequest low only in the acknowledge cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      waitreq_q <= 1'b1;
    end else begin
      waitreq_q <= !((bus_state_q == lamp_pkg::BUS_IDLE) && req);
    end
  end

  // Read data captured as the request is first seen
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      rdata_q <= 32'h0000_0000;
    end else if ((bus_state_q == lamp_pkg::BUS_IDLE) && AVS_READ_I) begin
      rdata_q <= rd_mux;
    end
  end

  // Byte enables widened to a bit mask
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{AVS_BYTEENABLE_I[b]}};
  end

  // Register words as seen by software
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[RL +: 2] = run_command_source_sel_q;
    ctrl_word[FL +: 3] = frequency_reference_source_sel_q;
    ctrl_word[lamp_pkg::CTRL_KEY_EN_BIT] = local_remote_key_enable_q;
    minf_word = 32'h0000_0000;
    minf_word[FREQ_W-1:0] = minimum_output_frequency_q;
  end

  // Status and raw input views
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[lamp_pkg::STAT_FWD]    = fwd_lamp_q;
    stat_word[lamp_pkg::STAT_REV]    = rev_lamp_q;
    stat_word[lamp_pkg::STAT_ALARM]  = alarm_lamp_q;
    stat_word[lamp_pkg::STAT_SEQ]    = seq_lamp_q;
    stat_word[lamp_pkg::STAT_REF]    = ref_lamp_q;
    stat_word[lamp_pkg::STAT_RUN]    = run_lamp_q;
    stat_word[lamp_pkg::STAT_STOP]   = stop_lamp_q;
    stat_word[lamp_pkg::STAT_REMOTE] = remote_q;
    stat_word[lamp_pkg::STAT_STOPKY] = stop_key_seen_q;
    input_word = 32'h0000_0000;
    input_word[6:0] = {ref_below_min, DECELERATING_I, RUNNING_I,
                       ALARM_I, FAULT_I, RUN_REV_I, RUN_FWD_I};
  end

  // Merged write values
  assign ctrl_new = (ctrl_word & ~wmask) | (AVS_WRITEDATA_I & wmask);
  assign minf_new = (minf_word & ~wmask) | (AVS_WRITEDATA_I & wmask);

  // Read decode, unmapped reads return zero
  always_comb begin
    unique case (AVS_ADDRESS_I)
      lamp_pkg::OFS_CTRL:  rd_mux = ctrl_word;
      lamp_pkg::OFS_MINF:  rd_mux = minf_word;
      lamp_pkg::OFS_STAT:  rd_mux = stat_word;
      lamp_pkg::OFS_INPUT: rd_mux = input_word;
      default:             rd_mux = lamp_pkg::UNMAPPED_RDATA;
    endcase
  end

  // Control register write
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      run_command_source_sel_q         <= lamp_pkg::RUN_SEL_RST;
      frequency_reference_source_sel_q <= lamp_pkg::REF_SEL_RST;
      local_remote_key_enable_q        <= lamp_pkg::KEY_EN_RST;
    end else if (commit_wr && (AVS_ADDRESS_I == lamp_pkg::OFS_CTRL)) begin
      run_command_source_sel_q         <= ctrl_new[RL +: 2];
      frequency_reference_source_sel_q <= ctrl_new[FL +: 3];
      local_remote_key_enable_q        <=
        ctrl_new[lamp_pkg::CTRL_KEY_EN_BIT];
    end
  end

  // Minimum output frequency write
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      minimum_output_frequency_q <= FREQ_W'(lamp_pkg::MINF_RST);
    end else if (commit_wr && (AVS_ADDRESS_I == lamp_pkg::OFS_MINF)) begin
      minimum_output_frequency_q <= minf_new[FREQ_W-1:0];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      remote_q <= lamp_pkg::REMOTE_RST;
    end else if (LOCAL_REMOTE_KEY_I && local_remote_key_enable_q) begin
      remote_q <= ~remote_q;
    end
  end

  // remember stop key while running remote
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      stop_key_seen_q <= 1'b0;
    end else if (STOP_KEY_I && RUNNING_I && remote_q) begin
      stop_key_seen_q <= 1'b1; // Set wins over clear
    end else if (!RUNNING_I || !remote_q) begin
      stop_key_seen_q <= 1'b0;
    end
  end

  assign run_cmd       = RUN_FWD_I | RUN_REV_I;
  assign ref_below_min = FREQ_REF_I < minimum_output_frequency_q;

  assign seq_remote_src =
    (run_command_source_sel_q != lamp_pkg::RUN_SEL_KEYPAD);

  // codes 1 to 4 light the lamp
  assign ref_remote_src =
    (frequency_reference_source_sel_q != lamp_pkg::REF_SEL_KEYPAD) &&
    (frequency_reference_source_sel_q <= lamp_pkg::REF_SEL_PULSE);

  // Alarm lamp mode
  always_comb begin
    if (FAULT_I) begin
      alarm_mode = lamp_pkg::LAMP_ON;
    end else if (ALARM_I) begin
      alarm_mode = lamp_pkg::LAMP_BLINK;
    end else begin
      alarm_mode = lamp_pkg::LAMP_OFF;
    end
  end

  always_comb begin
    if (DECELERATING_I) begin
      run_mode = lamp_pkg::LAMP_BLINK;
    end else if (RUNNING_I) begin
      run_mode = lamp_pkg::LAMP_ON;
    end else begin
      run_mode = lamp_pkg::LAMP_OFF;
    end
  end

  // Stop lamp mode, blinking conditions first
  always_comb begin
    if (run_cmd && ref_below_min) begin
      stop_mode = lamp_pkg::LAMP_BLINK;
    end else if (stop_key_seen_q && RUNNING_I) begin
      stop_mode = lamp_pkg::LAMP_BLINK;
    end else if (DECELERATING_I || !RUNNING_I) begin
      stop_mode = lamp_pkg::LAMP_ON;
    end else begin
      stop_mode = lamp_pkg::LAMP_OFF;
    end
  end

  // Mode to lamp level using the shared phase
  function automatic logic lamp_level(lamp_pkg::lamp_mode_t m,
                                      logic ph);
    unique case (m)
      lamp_pkg::LAMP_ON:    lamp_level = 1'b1;
      lamp_pkg::LAMP_BLINK: lamp_level = ph;
      default:              lamp_level = 1'b0;
    endcase
  endfunction : lamp_level

  // Direction lamps
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      fwd_lamp_q <= 1'b0;
      rev_lamp_q <= 1'b0;
    end else begin
      fwd_lamp_q <= RUN_FWD_I;
      rev_lamp_q <= RUN_REV_I;
    end
  end

  // Source lamps
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      seq_lamp_q <= 1'b0;
      ref_lamp_q <= 1'b0;
    end else begin
      seq_lamp_q <= remote_q & seq_remote_src;
      ref_lamp_q <= remote_q & ref_remote_src;
    end
  end

  // Alarm, run and stop lamps
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      alarm_lamp_q <= 1'b0;
      run_lamp_q   <= 1'b0;
      stop_lamp_q  <= 1'b0;
    end else begin
      alarm_lamp_q <= lamp_level(alarm_mode, blink_phase);
      run_lamp_q   <= lamp_level(run_mode, blink_phase);
      stop_lamp_q  <= lamp_level(stop_mode, blink_phase);
    end
  end

  // Outputs, all from flops
  assign AVS_READDATA_O           = rdata_q;
  assign AVS_WAITREQUEST_O        = waitreq_q;
  assign FORWARD_RUN_LAMP_O       = fwd_lamp_q;
  assign REVERSE_RUN_LAMP_O       = rev_lamp_q;
  assign ALARM_LAMP_O             = alarm_lamp_q;
  assign REMOTE_RUN_SOURCE_LAMP_O = seq_lamp_q;
  assign REMOTE_REF_SOURCE_LAMP_O = ref_lamp_q;
  assign RUN_LAMP_O               = run_lamp_q;
  assign STOP_LAMP_O              = stop_lamp_q;
  assign REMOTE_MODE_O            = remote_q;

endmodule : drive_status_lamps

// File: design/lamp_blink_gen.sv
// Shared blink phase divider for the status lamps
`timescale 1ns/1ps
module lamp_blink_gen #(
  parameter int unsigned HALF_CYC = 100
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  output logic      phase_o
);

  logic [31:0] cnt_q;
  logic        phase_q;
  logic        wrap;

  // End of one half period
  assign wrap = (cnt_q == 32'(HALF_CYC - 1));

  // Half period counter
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_q <= 32'h0000_0000;
    end else if (wrap) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  // Phase flips each half period
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      phase_q <= 1'b0;
    end else if (wrap) begin
      phase_q <= ~phase_q;
    end
  end

  assign phase_o = phase_q;

endmodule : lamp_blink_gen

// File: design/lamp_pkg.sv
// Constants and types for the drive status lamp block
package lamp_pkg;

  // Clock rate and blink cadence
  localparam int CLK_FREQ_KHZ   = 200000;
  localparam int BLINK_HALF_MS  = 500;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_FREQ_KHZ;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL  = 4'h0;
  localparam logic [3:0] OFS_MINF  = 4'h4;
  localparam logic [3:0] OFS_STAT  = 4'h8;
  localparam logic [3:0] OFS_INPUT = 4'hC;

  // Control register field positions
  localparam int CTRL_RUN_SEL_LSB = 0;
  localparam int CTRL_REF_SEL_LSB = 4;
  localparam int CTRL_KEY_EN_BIT  = 8;

  // Values after reset
  localparam logic [1:0]  RUN_SEL_RST = 2'h1;
  localparam logic [2:0]  REF_SEL_RST = 3'h1;
  localparam logic        KEY_EN_RST  = 1'b1;
  localparam logic [15:0] MINF_RST    = 16'h0000;
  localparam logic        REMOTE_RST  = 1'b1;

  // Source selection codes
  localparam logic [1:0] RUN_SEL_KEYPAD = 2'h0;
  localparam logic [2:0] REF_SEL_KEYPAD = 3'h0;
  localparam logic [2:0] REF_SEL_PULSE  = 3'h4;

  // Status register bit positions
  localparam int STAT_FWD    = 0;
  localparam int STAT_REV    = 1;
  localparam int STAT_ALARM  = 2;
  localparam int STAT_SEQ    = 3;
  localparam int STAT_REF    = 4;
  localparam int STAT_RUN    = 5;
  localparam int STAT_STOP   = 6;
  localparam int STAT_REMOTE = 7;
  localparam int STAT_STOPKY = 8;

  // Answer to an unmapped read
  localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;

  // Lamp drive modes
  typedef enum logic [1:0] {LAMP_OFF, LAMP_ON, LAMP_BLINK} lamp_mode_t;

  // Bus slave states
  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

endpackage : lamp_pkg

// File: tb/drive_seq_model.sv
// Behavioural model of the drive sequencer feeding the lamp block
`timescale 1ns/1ps
module drive_seq_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] state_i,
  output logic            run_fwd_o,
  output logic            run_rev_o,
  output logic            running_o,
  output logic            decel_o
);
  logic [1:0] st_q = 2'h0;

  // State 0 stopped, 1 forward, 2 reverse, 3 ramping down
  always @(posedge clk_i) begin
    st_q <= state_i;
  end

  // Status levels; run commands drop once ramp-down starts
  assign run_fwd_o = (st_q == 2'h1);
  assign run_rev_o = (st_q == 2'h2);
  assign running_o = (st_q != 2'h0);
  assign decel_o   = (st_q == 2'h3);
endmodule : drive_seq_model

// File: tb/drive_status_lamps_tb_top.sv
// Self-checking bench for the drive status lamp block
`timescale 1ns/1ps
module drive_status_lamps_tb_top;
  localparam int HALF = 8;
  localparam int WIN  = 2 * HALF + 4;
  logic        clk   = 1'b0;
  logic        rstn  = 1'b0;
  logic [3:0]  adr   = 4'h0;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic [3:0]  be    = 4'hF;
  logic [31:0] wd    = 32'h0;
  logic [31:0] rq;
  logic        wq;
  logic        fault = 1'b0;
  logic        alarm = 1'b0;
  logic [15:0] freq  = 16'h0;
  logic        skey  = 1'b0;
  logic        lkey  = 1'b0;
  logic [1:0]  st    = 2'h0;
  logic        forward_run_lamp, reverse_run_lamp, running, decel, mode;
  logic [6:0]  lamp;
  int          miscompares = 0;
  int          n_tests     = 0;
  string       nm [7] = '{"fwd_lamp", "rev_lamp", "alarm", "run_src",
                          "ref_src", "run", "stop"};

  // Clock, 5 ns period
  initial begin
    forever #2.5 clk = ~clk;
  end

  drive_seq_model drive_seq_model_i (.clk_i(clk), .state_i(st),
    .run_fwd_o(forward_run_lamp), .run_rev_o(reverse_run_lamp), .running_o(running), .decel_o(decel));

  drive_status_lamps #(.BLINK_HALF_CYC(HALF)) drive_status_lamps_i (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wd),
    .AVS_READDATA_O(rq), .AVS_WAITREQUEST_O(wq), .RUN_FWD_I(forward_run_lamp),
    .RUN_REV_I(reverse_run_lamp), .FAULT_I(fault), .ALARM_I(alarm), .RUNNING_I(running),
    .DECELERATING_I(decel), .FREQ_REF_I(freq), .STOP_KEY_I(skey),
    .LOCAL_REMOTE_KEY_I(lkey), .FORWARD_RUN_LAMP_O(lamp[0]),
    .REVERSE_RUN_LAMP_O(lamp[1]), .ALARM_LAMP_O(lamp[2]),
    .REMOTE_RUN_SOURCE_LAMP_O(lamp[3]), .REMOTE_REF_SOURCE_LAMP_O(lamp[4]),
    .RUN_LAMP_O(lamp[5]), .STOP_LAMP_O(lamp[6]), .REMOTE_MODE_O(mode));

  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 64);
    q = rq;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 64) begin
      miscompares++;
      stop_test();
    end
  endtask : bus

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wreg

  task automatic rchk(input string s, input logic [3:0] a, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(s, e, q);
  endtask : rchk

  // One-cycle key press, stop key or mode key
  task automatic press(input logic stopkey);
    @(posedge clk);
    if (stopkey) begin
      skey <= 1'b1;
    end else begin
      lkey <= 1'b1;
    end
    @(posedge clk);
    skey <= 1'b0;
    lkey <= 1'b0;
  endtask : press

  // Lamp modes per lamp: 0 dark, 1 lit, b blinking, - not looked at
  task automatic lamps(input string e);
    int ones [7] = '{default: 0};
    repeat (3) @(posedge clk);
    repeat (WIN) begin
      @(negedge clk);
      for (int i = 0; i < 7; i++) begin
        if (lamp[i] === 1'b1) begin
          ones[i]++;
        end
      end
    end
    for (int i = 0; i < 7; i++) begin
      if (e[i] != "-") begin
        n_tests++;
        if ((e[i] == "0" && ones[i] != 0) || (e[i] == "1" && ones[i] != WIN)
            || (e[i] == "b" && (ones[i] == 0 || ones[i] == WIN))) begin
          miscompares++;
          $display("[FAIL] %s expected %c seen lit %0d", nm[i], e[i], ones[i]);
        end
      end
    end
  endtask : lamps

  // Reset values, unmapped and read-only places, byte lanes
  task automatic t_regs();
    rchk("ctrl", 4'h0, 32'h0000_0111);
    rchk("minf", 4'h4, 32'h0000_0000);
    rchk("unmapped", 4'h2, 32'h0000_0000);
    wreg(4'h8, 32'hFFFF_FFFF);
    rchk("stat", 4'h8, 32'h0000_00D8);
    be <= 4'h1;
    wreg(4'h0, 32'h0000_0000);
    be <= 4'hF;
    rchk("ctrl_lane", 4'h0, 32'h0000_0100);
    wreg(4'h0, 32'h0000_0111);
  endtask : t_regs

  // Direction lamps and the stop lamp while running
  task automatic t_dir();
    st <= 2'h1;
    lamps("1001110");
    rchk("stat_fwd", 4'h8, 32'h0000_00B9);
    st <= 2'h2;
    lamps("0101110");
  endtask : t_dir

  // Fault wins over alarm; alarm and ramp-down blink together
  task automatic t_alarm();
    st <= 2'h0;
    fault <= 1'b1;
    alarm <= 1'b1;
    lamps("0011101");
    fault <= 1'b0;
    lamps("00b1101");
    st <= 2'h3;
    lamps("00b11b1");
    alarm <= 1'b0;
    st <= 2'h0;
    lamps("0001101");
  endtask : t_alarm

  // Source selections, then local mode and the key enable
  task automatic t_src();
    string e;
    for (int r = 0; r < 4; r++) begin
      wreg(4'h0, 32'h0000_0110 | r);
      e = "-------";
      e[3] = (r != 0) ? "1" : "0";
      lamps(e);
    end
    for (int f = 0; f < 8; f++) begin
      wreg(4'h0, 32'h0000_0101 | (f << 4));
      e = "-------";
      e[4] = (f != 0 && f < 5) ? "1" : "0";
      lamps(e);
    end
    wreg(4'h0, 32'h0000_0111);
    press(1'b0);
    lamps("---00--");
    chk("mode_local", 32'h0, mode);
    wreg(4'h0, 32'h0000_0011);
    press(1'b0);
    lamps("---00--");
    chk("mode_locked", 32'h0, mode);
    wreg(4'h0, 32'h0000_0111);
    press(1'b0);
    lamps("---11--");
    chk("mode_remote", 32'h1, mode);
  endtask : t_src

  // Reference below minimum and a remote stop key while running
  task automatic t_below();
    wreg(4'h4, 32'h0000_0064);
    rchk("minf_wr", 4'h4, 32'h0000_0064);
    freq <= 16'h0032;
    st <= 2'h1;
    lamps("-----1b");
    wreg(4'hC, 32'hFFFF_FFFF);
    rchk("input", 4'hC, 32'h0000_0051);
    freq <= 16'h0064;
    lamps("-----10");
    press(1'b1);
    lamps("-----1b");
    st <= 2'h0;
    lamps("-----01");
    st <= 2'h1;
    lamps("-----10");
  endtask : t_below

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_dir();
    t_alarm();
    t_src();
    t_below();
    stop_test();
  end
endmodule : drive_status_lamps_tb_top

// File: tb/lamp_chk_asserts.sv
// Port-level assertions for the drive status lamp block
`timescale 1ns/1ps
module lamp_chk (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic RUN_FWD_I,
  input wire logic RUN_REV_I,
  input wire logic FAULT_I,
  input wire logic ALARM_I,
  input wire logic RUNNING_I,
  input wire logic DECELERATING_I,
  input wire logic LOCAL_REMOTE_KEY_I,
  input wire logic FORWARD_RUN_LAMP_O,
  input wire logic REVERSE_RUN_LAMP_O,
  input wire logic ALARM_LAMP_O,
  input wire logic REMOTE_RUN_SOURCE_LAMP_O,
  input wire logic REMOTE_REF_SOURCE_LAMP_O,
  input wire logic RUN_LAMP_O,
  input wire logic STOP_LAMP_O,
  input wire logic REMOTE_MODE_O
);
  logic live_q;

  // High when the previous edge was out of reset
  always_ff @(posedge SYS_CLK_I) begin
    live_q <= RSTN_I;
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);

  property p_fwd;
    live_q |-> FORWARD_RUN_LAMP_O == $past(RUN_FWD_I);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward lamp wrong");
  property p_rev;
    live_q |-> REVERSE_RUN_LAMP_O == $past(RUN_REV_I);
  endproperty
  a_rev: assert property (p_rev) else $error("reverse lamp wrong");
  property p_flt;
    live_q && $past(FAULT_I) |-> ALARM_LAMP_O;
  endproperty
  a_flt: assert property (p_flt) else $error("fault lamp dark");
  property p_quiet;
    live_q && $past(!FAULT_I && !ALARM_I) |-> !ALARM_LAMP_O;
  endproperty
  a_quiet: assert property (p_quiet) else $error("alarm lamp lit");
  property p_phase;
    live_q && $past(ALARM_I && !FAULT_I && DECELERATING_I)
      |-> ALARM_LAMP_O == RUN_LAMP_O;
  endproperty
  a_phase: assert property (p_phase) else $error("phase split");
  property p_seq;
    live_q && REMOTE_RUN_SOURCE_LAMP_O |-> $past(REMOTE_MODE_O);
  endproperty
  a_seq: assert property (p_seq) else $error("run source lit");
  property p_ref;
    live_q && REMOTE_REF_SOURCE_LAMP_O |-> $past(REMOTE_MODE_O);
  endproperty
  a_ref: assert property (p_ref) else $error("ref source lit");
  property p_run;
    live_q && $past(!DECELERATING_I) |-> RUN_LAMP_O == $past(RUNNING_I);
  endproperty
  a_run: assert property (p_run) else $error("run lamp wrong");
  property p_stop;
    live_q && $past(!RUNNING_I && !RUN_FWD_I && !RUN_REV_I) |-> STOP_LAMP_O;
  endproperty
  a_stop: assert property (p_stop) else $error("stop lamp dark");
  // mode moves only on a key press
  property p_mode;
    live_q && $changed(REMOTE_MODE_O) |-> $past(LOCAL_REMOTE_KEY_I);
  endproperty
  a_mode: assert property (p_mode) else $error("mode changed");
  // Answer only to a request, low for one cycle
  property p_ack;
    live_q && !AVS_WAITREQUEST_O
      |-> $past(AVS_READ_I || AVS_WRITE_I) ##1 AVS_WAITREQUEST_O;
  endproperty
  a_ack: assert property (p_ack) else $error("bad waitrequest");
endmodule : lamp_chk

bind drive_status_lamps lamp_chk lamp_chk_i (.SYS_CLK_I, .RSTN_I,
  .AVS_READ_I, .AVS_WRITE_I, .AVS_WAITREQUEST_O, .RUN_FWD_I, .RUN_REV_I,
  .FAULT_I, .ALARM_I, .RUNNING_I, .DECELERATING_I, .LOCAL_REMOTE_KEY_I,
  .FORWARD_RUN_LAMP_O, .REVERSE_RUN_LAMP_O, .ALARM_LAMP_O,
  .REMOTE_RUN_SOURCE_LAMP_O, .REMOTE_REF_SOURCE_LAMP_O, .RUN_LAMP_O,
  .STOP_LAMP_O, .REMOTE_MODE_O);
